//--- logic/pls_ctrl.sv
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`include "pls_defines.svh"

// Notes on behaviour
// - Multiplier zero means bypass; reset leaves bypass with multiplier zero.
// - Codes 1..10 multiply oscillator; halved when halver control is clear.
// - System clock output follows the selected CPU input clock exactly.
// - Registers reset only by external pin or watchdog reset.
// - Ratio writes accepted only while protected write enable is active.
// - Status bit 6 disables loss detector and limp-mode clock when set.
// - Status bit 5 gates oscillator feed to PLL for loss testing.
// - Watchdog works gated only with external clock; disable beforehand.
// - Loss-clear bit reads zero; writing zero does nothing.
// - Writing one to loss-clear resets detection; loss may recur.
// - Loss flag ignores writes; cleared by loss-clear or external reset.
// - Loss flag is one after detected loss and limp switch, else zero.
// - Status bit 0 reads zero while locking and one once stable.
// - Ratio write forces half oscillator until lock, then new ratio.
// - Status bit 1 clear enables halving, set disables halving.
module pls_ctrl
  import pls_pkg::*;
#(
  parameter int unsigned LOCK_CYCLES = `PLS_LOCK_CYCLES
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ext_reset_i,
  input  wire logic        wdog_reset_i,
  input  wire logic        protected_write_enable_i,
  input  wire logic        osc_loss_detected_i,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output pls_clk_sel_s     clk_sel_o,
  output logic             limp_select_o,
  output logic             osc_feed_gate_o,
  output logic             osc_loss_detect_disable_o,
  output logic             osc_loss_clear_o,
  output logic             lock_done_o
);

  // ===================================================================
  // Pin synchronisers and reset qualification
  logic [1:0] ext_rst_sync;
  logic [1:0] loss_sync;
  logic       hard_reset;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ext_rst_sync <= 2'b00;
      loss_sync    <= 2'b00;
    end else begin
      ext_rst_sync <= {ext_rst_sync[0], ext_reset_i};
      loss_sync    <= {loss_sync[0], osc_loss_detected_i};
    end
  end

  // Only external pin or watchdog reset restores the registers
  assign hard_reset = ext_rst_sync[1] | wdog_reset_i;

  // ===================================================================
  // APB decode
  function automatic logic addr_hit(input logic [11:0] a,
                                    input logic [11:0] base);
    addr_hit = (a == base);
  endfunction

  logic acc;
  logic wr_ratio;
  logic wr_status;
  logic mapped;

  assign acc       = psel & penable & pready;
  assign mapped    = addr_hit(paddr, `PLS_ADDR_RATIO)
                   | addr_hit(paddr, `PLS_ADDR_STATUS);
  assign wr_ratio  = acc & pwrite & addr_hit(paddr, `PLS_ADDR_RATIO)
                   & protected_write_enable_i;
  assign wr_status = acc & pwrite & addr_hit(paddr, `PLS_ADDR_STATUS);

  // One wait state: ready on the second access cycle
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      pready <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
    end
  end

  // Unmapped address answers with an error
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel & penable & ~pready & ~mapped;
    end
  end

  // ===================================================================
  // Ratio control register
  logic [3:0] ratio;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || hard_reset) begin
      ratio <= `PLS_RATIO_BYPASS;
    end else if (wr_ratio) begin
      ratio <= pwdata[3:0];
    end
  end

  // ===================================================================
  // Status control bits
  logic halver_off;
  logic feed_gate;
  logic det_dis;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || hard_reset) begin
      halver_off <= 1'b0;
      feed_gate  <= 1'b0;
      det_dis    <= 1'b0;
    end else if (wr_status) begin
      halver_off <= pwdata[`PLS_BIT_HALVER];
      feed_gate  <= pwdata[`PLS_BIT_FEED_GATE];
      det_dis    <= pwdata[`PLS_BIT_DET_DIS];
    end
  end

  // Loss-clear pulse, only on a written one
  logic clr_req;
  assign clr_req = wr_status & pwdata[`PLS_BIT_LOSS_CLR];

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      osc_loss_clear_o <= 1'b0;
    end else begin
      osc_loss_clear_o <= clr_req;
    end
  end

  // Loss flag: set by detector (wins over clear), writes ignored
  logic loss_flag;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || ext_rst_sync[1]) begin
      loss_flag <= 1'b0;
    end else if (loss_sync[1] && !det_dis) begin
      loss_flag <= 1'b1;
    end else if (clr_req) begin
      loss_flag <= 1'b0;
    end
  end

  // ===================================================================
  // Lock sequencer
  pls_state_e               state;
  logic [`PLS_CNT_W-1:0]    lock_cnt;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || hard_reset) begin
      state    <= PLS_ST_LOCKED;
      lock_cnt <= '0;
    end else begin
      case (state)
        PLS_ST_LOCKED: begin
          if (wr_ratio) begin
            state    <= PLS_ST_LOCKING;
            lock_cnt <= '0;
          end
        end
        PLS_ST_LOCKING: begin
          if (wr_ratio) begin
            lock_cnt <= '0;
          end else if (lock_cnt == LOCK_CYCLES[`PLS_CNT_W-1:0] - 1'b1) begin
            state <= PLS_ST_LOCKED;
          end else begin
            lock_cnt <= lock_cnt + 1'b1;
          end
        end
        default: begin
          state <= PLS_ST_LOCKED;
        end
      endcase
    end
  end

  // ===================================================================
  // Clock selection outputs
  pls_clk_sel_s next_clk_sel;
  logic         locking;

  assign locking = (state == PLS_ST_LOCKING);

  always_comb begin
    next_clk_sel.mult   = ratio;
    next_clk_sel.bypass = (ratio == `PLS_RATIO_BYPASS)
                        | (ratio > `PLS_RATIO_MAX);
    next_clk_sel.halve  = ~halver_off;
    if (locking) begin
      // Half oscillator until the PLL settles
      next_clk_sel.bypass = 1'b1;
      next_clk_sel.halve  = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      clk_sel_o                 <= '{bypass: 1'b1, halve: 1'b1,
                                     mult: `PLS_RATIO_BYPASS};
      lock_done_o               <= 1'b1;
      limp_select_o             <= 1'b0;
      osc_feed_gate_o           <= 1'b0;
      osc_loss_detect_disable_o <= 1'b0;
    end else begin
      clk_sel_o                 <= next_clk_sel;
      lock_done_o               <= ~locking;
      limp_select_o             <= loss_flag & ~det_dis;
      osc_feed_gate_o           <= feed_gate;
      osc_loss_detect_disable_o <= det_dis;
    end
  end

  // ===================================================================
  // Read data
  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (addr_hit(paddr, `PLS_ADDR_RATIO)) begin
      next_rdata[3:0] = ratio;
    end else if (addr_hit(paddr, `PLS_ADDR_STATUS)) begin
      next_rdata[`PLS_BIT_LOCK]      = ~locking;
      next_rdata[`PLS_BIT_HALVER]    = halver_off;
      next_rdata[`PLS_BIT_LOSS_FLAG] = loss_flag;
      next_rdata[`PLS_BIT_LOSS_CLR]  = 1'b0;
      next_rdata[`PLS_BIT_FEED_GATE] = feed_gate;
      next_rdata[`PLS_BIT_DET_DIS]   = det_dis;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      prdata <= 32'h0000_0000;
    end else if (psel && penable && !pready && !pwrite) begin
      prdata <= next_rdata;
    end
  end

endmodule

//--- logic/pls_defines.svh
`ifndef PLS_DEFINES_SVH
`define PLS_DEFINES_SVH

// =====================================================================
// Register map (byte addresses on APB)
`define PLS_ADDR_RATIO      12'h000
`define PLS_ADDR_STATUS     12'h004
`define PLS_ADDR_W          12

// =====================================================================
// Ratio control fields
`define PLS_RATIO_W         4
`define PLS_RATIO_BYPASS    4'h0
`define PLS_RATIO_MAX       4'ha

// =====================================================================
// Status fields
`define PLS_BIT_LOCK        0
`define PLS_BIT_HALVER      1
`define PLS_BIT_LOSS_FLAG   3
`define PLS_BIT_LOSS_CLR    4
`define PLS_BIT_FEED_GATE   5
`define PLS_BIT_DET_DIS     6

// =====================================================================
// Timing: PLL lock time in microseconds and derived cycles at 25 MHz
`define PLS_CLK_MHZ         25
`define PLS_LOCK_TIME_US    100
`define PLS_LOCK_CYCLES     (`PLS_LOCK_TIME_US * `PLS_CLK_MHZ)
`define PLS_CNT_W           16

`endif

//--- logic/pls_pkg.sv
package pls_pkg;

  // Lock sequencer states
  typedef enum logic [1:0] {
    PLS_ST_LOCKED  = 2'b01,
    PLS_ST_LOCKING = 2'b10
  } pls_state_e;

  // Clock selection that steers the clock mux outside
  typedef struct packed {
    logic       bypass;
    logic       halve;
    logic [3:0] mult;
  } pls_clk_sel_s;

endpackage

//--- tb/pls_ctrl_props.sv
`timescale 1ns/1ns
// ==========================================================
// Port checker for the ratio and status block
module pls_props
  import pls_pkg::*;
#(
  parameter int unsigned LOCK_CYCLES = 8
) (
  input wire logic        ref_clk_i,
  input wire logic        rst_n_i,
  input wire logic        ext_reset_i,
  input wire logic        wdog_reset_i,
  input wire logic        protected_write_enable_i,
  input wire logic        osc_loss_detected_i,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire pls_clk_sel_s clk_sel_o,
  input wire logic        limp_select_o,
  input wire logic        osc_feed_gate_o,
  input wire logic        osc_loss_detect_disable_o,
  input wire logic        osc_loss_clear_o,
  input wire logic        lock_done_o
);
  localparam int LK = LOCK_CYCLES + 3;
  logic wst;
  logic wra;
  // Writes taken at each register
  assign wst = psel && penable && pready && pwrite && paddr == 12'h004;
  assign wra = psel && penable && pready && pwrite && paddr == 12'h000;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_reset_bypass: assert property ($rose(rst_n_i) |->
    clk_sel_o.bypass && clk_sel_o.mult == 4'h0 && lock_done_o)
    else $error("bad state after reset");
  a_ready_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("ready timing");
  a_clear_pulse: assert property (wst && pwdata[4] |=> osc_loss_clear_o)
    else $error("no clear pulse");
  a_clear_cause: assert property (osc_loss_clear_o |->
    $past(wst && pwdata[4])) else $error("stray clear pulse");
  // Register bits reach the outputs one cycle after they land
  a_gate_bits: assert property (wst |-> ##2
    osc_feed_gate_o == $past(pwdata[5], 2)
    && osc_loss_detect_disable_o == $past(pwdata[6], 2))
    else $error("gate bits");
  a_halver_ctl: assert property (wst && lock_done_o |-> ##2
    clk_sel_o.halve != $past(pwdata[1], 2)) else $error("halver");
  a_lock_start: assert property (wra && protected_write_enable_i &&
    pwdata[3:0] <= 4'ha |-> ##2 !lock_done_o && clk_sel_o.bypass
    && clk_sel_o.halve) else $error("lock start");
  a_lock_end: assert property ($fell(lock_done_o) |-> ##[1:LK] lock_done_o)
    else $error("lock too long");
  a_write_guard: assert property (wra && !protected_write_enable_i &&
    lock_done_o |=> lock_done_o && $stable(clk_sel_o)) else $error("guard");
  a_wdog_reset: assert property (wdog_reset_i |-> ##2
    clk_sel_o.mult == 4'h0 && !osc_feed_gate_o && lock_done_o)
    else $error("watchdog reset");
  c_ratio: cover property (wra && protected_write_enable_i);
  c_limp: cover property ($rose(limp_select_o));
  c_clear: cover property (osc_loss_clear_o);
endmodule

bind pls_ctrl pls_props #(.LOCK_CYCLES(LOCK_CYCLES)) u_props (.*);

//--- tb/test_pll_ratio_and_osc_loss_status.sv
`timescale 1ns/1ns
// ==========================================================
// Self-checking bench for the ratio and status block
module test_pll_ratio_and_osc_loss_status
  import pls_pkg::*;
;
  logic ref_clk_i = 0, rst_n_i = 0, ext_reset_i = 0, wdog_reset_i = 0;
  logic protected_write_enable_i = 1, osc_loss_detected_i = 0;
  logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic limp_select_o, osc_feed_gate_o, osc_loss_detect_disable_o;
  logic osc_loss_clear_o, lock_done_o;
  logic [3:0] code;
  pls_clk_sel_s clk_sel_o;
  int fails = 0, checks_done = 0, seed = 32'h03964b50, i;
  // Clock and design
  always #20 ref_clk_i = ~ref_clk_i;
  pls_ctrl #(.LOCK_CYCLES(8)) uut (.*);
  task automatic give_verdict;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("Error %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tk(input int k);
    repeat (k) @(posedge ref_clk_i);
  endtask
  // One APB transfer, bounded wait on ready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk_i);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_i);
    penable <= 1;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    if (n >= 20) begin
      fails++;
      give_verdict;
    end
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(0, a, 0);
    chk(rd, e);
  endtask
  task automatic wait_lock;
    int n;
    n = 0;
    // Let the lock indication drop after a fresh ratio write
    tk(2);
    while (lock_done_o !== 1'b1 && n < 50) begin
      tk(1);
      n++;
    end
    if (n >= 50) begin
      fails++;
      give_verdict;
    end
  endtask
  task automatic loss;
    osc_loss_detected_i <= 1;
    tk(2);
    osc_loss_detected_i <= 0;
    tk(4);
  endtask
  // Main sequence
  initial begin
    tk(20);
    rst_n_i <= 1;
    rdc(12'h000, 0);
    rdc(12'h004, 1);
    chk(clk_sel_o, 6'h30);
    apb(0, 12'h008, 0);
    chk({err, rd[30:0]}, 32'h80000000);
    apb(1, 12'h004, 0);
    for (i = 0; i < 6; i++) begin
      code = i == 0 ? 4'ha : i == 1 ? 4'h1 : 4'(1 + $unsigned($random(seed)) % 10);
      apb(1, 12'h000, {28'h0, code});
      rdc(12'h004, 0);
      chk(clk_sel_o, {2'b11, code});
      wait_lock;
      rdc(12'h000, {28'h0, code});
      chk(clk_sel_o, {2'b01, code});
    end
    apb(1, 12'h004, 2);
    tk(2);
    chk(clk_sel_o, {2'b00, code});
    apb(1, 12'h004, 0);
    protected_write_enable_i <= 0;
    apb(1, 12'h000, 5);
    rdc(12'h000, {28'h0, code});
    protected_write_enable_i <= 1;
    apb(1, 12'h000, 15);
    wait_lock;
    chk(clk_sel_o.bypass, 1);
    apb(1, 12'h000, 3);
    wait_lock;
    apb(1, 12'h004, 32'hffffffff);
    rdc(12'h004, 32'h63);
    chk({osc_feed_gate_o, osc_loss_detect_disable_o}, 3);
    loss;
    rdc(12'h004, 32'h63);
    chk(limp_select_o, 0);
    apb(1, 12'h004, 0);
    loss;
    rdc(12'h004, 9);
    chk(limp_select_o, 1);
    apb(1, 12'h004, $random(seed) & 32'hffffff88);
    rdc(12'h004, 9);
    apb(1, 12'h004, 16);
    tk(2);
    rdc(12'h004, 1);
    chk(limp_select_o, 0);
    apb(1, 12'h004, 32'h20);
    loss;
    wdog_reset_i <= 1;
    tk(1);
    wdog_reset_i <= 0;
    tk(2);
    rdc(12'h000, 0);
    rdc(12'h004, 9);
    ext_reset_i <= 1;
    tk(3);
    ext_reset_i <= 0;
    tk(4);
    rdc(12'h004, 1);
    give_verdict;
  end
endmodule
